// ===== inc/mrr_pkg.sv
// Package for the monitor result register bank: offsets, fields, resets, types.
// Assumes a single clock domain and 16-bit register words.
package mrr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_SHUNT_CH1 = 8'h01;
  localparam logic [7:0] OFS_BUS_CH1   = 8'h02;
  localparam logic [7:0] OFS_SHUNT_CH2 = 8'h03;
  localparam logic [7:0] OFS_BUS_CH2   = 8'h04;
  localparam logic [7:0] OFS_SHUNT_CH3 = 8'h05;
  localparam logic [7:0] OFS_BUS_CH3   = 8'h06;
  localparam logic [7:0] OFS_FAST_LIM1 = 8'h07;

  // ==========================================================
  // Field layout and reset values
  localparam int          SIGN_POS      = 15;
  localparam int          MAG_LSB       = 3;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [15:0] LIMIT_RESET   = 16'h7ff8;
  localparam logic [15:0] FIELD_MASK    = 16'hfff8;
  localparam int          NUM_CH        = 3;
  localparam int          AVG_SEL_W     = 3;
  localparam int          AVG_CNT_W     = 11;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        valid;
    logic [1:0]  chan;
    logic        is_bus;
    logic [15:0] code;
  } mrr_sample_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mrr_req_t;

  // Samples per averaged result for each selector code
  function automatic logic [AVG_CNT_W-1:0] avg_samples(input logic [AVG_SEL_W-1:0] sel);
    case (sel)
      3'h0:    avg_samples = 11'h001;
      3'h1:    avg_samples = 11'h004;
      3'h2:    avg_samples = 11'h010;
      3'h3:    avg_samples = 11'h040;
      3'h4:    avg_samples = 11'h080;
      3'h5:    avg_samples = 11'h100;
      3'h6:    avg_samples = 11'h200;
      default: avg_samples = 11'h400;
    endcase
  endfunction

endpackage

// ===== rtl/mrr_averager.sv
// Running averager for one measurement stream.
// Assumes samples arrive as one-cycle valid pulses in the shared clock.
module mrr_averager
  import mrr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 samp_valid,
  input  wire logic [15:0]          samp_code,
  input  wire logic [AVG_SEL_W-1:0] avg_sel,
  output logic                      avg_valid,
  output logic [15:0]               avg_code
);
  typedef struct packed {
    logic [26:0] acc;
    logic [10:0] cnt;
    logic        vld;
    logic [15:0] res;
  } mrr_avg_st_t;

  mrr_avg_st_t st_r;
  mrr_avg_st_t st_nxt;
  logic [26:0] sum;
  logic [26:0] shifted;
  logic [10:0] target;

  always_comb
  begin
    st_nxt  = st_r;
    target  = avg_samples(avg_sel);
    sum     = st_r.acc + {{11{samp_code[15]}}, samp_code};
    shifted = sum;
    // Power-of-two counts: divide by arithmetic shift
    case (avg_sel)
      3'h0:    shifted = sum;
      3'h1:    shifted = $signed(sum) >>> 2;
      3'h2:    shifted = $signed(sum) >>> 4;
      3'h3:    shifted = $signed(sum) >>> 6;
      3'h4:    shifted = $signed(sum) >>> 7;
      3'h5:    shifted = $signed(sum) >>> 8;
      3'h6:    shifted = $signed(sum) >>> 9;
      default: shifted = $signed(sum) >>> 10;
    endcase
    st_nxt.vld = 1'b0;
    if (samp_valid)
    begin
      if (st_r.cnt + 11'h001 >= target)
      begin
        st_nxt.res = shifted[15:0] & FIELD_MASK;
        st_nxt.vld = 1'b1;
        st_nxt.acc = '0;
        st_nxt.cnt = '0;
      end
      else
      begin
        st_nxt.acc = sum;
        st_nxt.cnt = st_r.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign avg_valid = st_r.vld;
  assign avg_code  = st_r.res;

  a_single_pass: assert property (@(posedge clk) disable iff (srst)
    (samp_valid && avg_sel == 3'h0) |=> avg_valid)
    else $error("single-sample mode did not publish");
endmodule

// ===== rtl/mrr_fast_compare.sv
// Compares each raw channel-one shunt conversion to the fast limit.
// Assumes limit and sample share the signed 13-bit field layout.
module mrr_fast_compare
  import mrr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        samp_valid,
  input  wire logic [15:0] samp_code,
  input  wire logic [15:0] limit,
  output logic             over_pulse
);
  typedef struct packed {
    logic over;
  } mrr_cmp_st_t;

  mrr_cmp_st_t st_r;
  mrr_cmp_st_t st_nxt;

  always_comb
  begin
    st_nxt.over = samp_valid &&
      ($signed(samp_code & FIELD_MASK) > $signed(limit & FIELD_MASK));
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign over_pulse = st_r.over;

  a_over_cause: assert property (@(posedge clk) disable iff (srst)
    over_pulse |-> $past(samp_valid))
    else $error("overcurrent flagged without a conversion");
endmodule

// ===== rtl/mrr_result_bank.sv
// Result and fast-limit register bank of a three-channel current/voltage monitor.
// Assumes a serial protocol engine presents 16-bit word accesses in this clock.
//
// Contract
// - Each channel has a shunt result register, at offsets 01h, 03h and 05h.
// - Each channel has a bus result register, at offsets 02h, 04h and 06h.
// - Results are signed twos complement with bit 15 as the sign.
// - Shunt magnitude sits in bits 14..3 and bits 2..0 read zero.
// - One shunt step is 40 uV, full scale 7FF8h at 163.8 mV.
// - Bus magnitude sits in bits 14..3 at 8 mV a step, full scale 7FF8h.
// - All six result registers are read-only and clear to zero at reset.
// - Every raw channel-one shunt conversion is compared to the fast limit.
// - The fast limit is a writable 13-bit field in bits 15..3, reset 7FF8h.
// - The averaging selector picks 1 to 1024 samples per result.
module mrr_result_bank
  import mrr_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  SRST,
  input  mrr_pkg::mrr_req_t          REQ,
  output logic [15:0]                RDATA,
  output logic                       RVALID,
  input  mrr_pkg::mrr_sample_t       SAMPLE,
  input  wire logic [2:0]            AVG_SEL,
  output logic                       FAST_OVER_CH1,
  output logic [15:0]                FAST_LIMIT_CH1
);
  import mrr_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [5:0][15:0] res;
    logic [15:0]      lim;
    logic [15:0]      rdata;
    logic             rvalid;
  } mrr_bank_st_t;

  mrr_bank_st_t st_r;
  mrr_bank_st_t st_nxt;

  logic [5:0]        avg_in_v;
  logic [5:0]        avg_out_v;
  logic [5:0][15:0]  avg_out_c;

  // Result slot is chan*2 + is_bus; offset is slot + 1
  function automatic logic [2:0] slot_of(input logic [1:0] ch, input logic bus);
    slot_of = 3'({ch, 1'b0} + {2'b00, bus});
  endfunction

  // ==========================================================
  // Averaging per stream
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_avg
      assign avg_in_v[g] = SAMPLE.valid && SAMPLE.chan < 2'd3 &&
                           slot_of(SAMPLE.chan, SAMPLE.is_bus) == 3'(g);
      mrr_averager u_avg (
        .clk        (REF_CLK),
        .srst       (SRST),
        .samp_valid (avg_in_v[g]),
        .samp_code  (SAMPLE.code),
        .avg_sel    (AVG_SEL),
        .avg_valid  (avg_out_v[g]),
        .avg_code   (avg_out_c[g])
      );
    end
  endgenerate

  // ==========================================================
  // Fast overcurrent compare, raw channel-one shunt samples
  mrr_fast_compare u_cmp (
    .clk        (REF_CLK),
    .srst       (SRST),
    .samp_valid (avg_in_v[0]),
    .samp_code  (SAMPLE.code),
    .limit      (st_r.lim),
    .over_pulse (FAST_OVER_CH1)
  );

  // ==========================================================
  // Register update and read decode
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = REQ.rd;
    for (int i = 0; i < 6; i++)
    begin
      if (avg_out_v[i])
        st_nxt.res[i] = avg_out_c[i] & FIELD_MASK;
    end
    // Only the limit takes writes; result offsets drop the write
    if (REQ.wr && REQ.addr == OFS_FAST_LIM1)
      st_nxt.lim = REQ.wdata & FIELD_MASK;
    if (REQ.rd)
    begin
      if (REQ.addr == OFS_SHUNT_CH1)
        st_nxt.rdata = st_r.res[0];
      else if (REQ.addr == OFS_BUS_CH1)
        st_nxt.rdata = st_r.res[1];
      else if (REQ.addr == OFS_SHUNT_CH2)
        st_nxt.rdata = st_r.res[2];
      else if (REQ.addr == OFS_BUS_CH2)
        st_nxt.rdata = st_r.res[3];
      else if (REQ.addr == OFS_SHUNT_CH3)
        st_nxt.rdata = st_r.res[4];
      else if (REQ.addr == OFS_BUS_CH3)
        st_nxt.rdata = st_r.res[5];
      else if (REQ.addr == OFS_FAST_LIM1)
        st_nxt.rdata = st_r.lim;
      else
        st_nxt.rdata = 16'h0000; // Unmapped reads return zero
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      st_r.res    <= {6{RESULT_RESET}};
      st_r.lim    <= LIMIT_RESET;
      st_r.rdata  <= 16'h0000;
      st_r.rvalid <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Word-wide port; byte split is the serial engine's job
  assign RDATA          = st_r.rdata;
  assign RVALID         = st_r.rvalid;
  assign FAST_LIMIT_CH1 = st_r.lim;

  // ==========================================================
  // Checks
  a_res_reset: assert property (@(posedge REF_CLK)
    SRST |=> (st_r.res == {6{RESULT_RESET}}))
    else $error("results not cleared by reset");
  a_lim_reset: assert property (@(posedge REF_CLK)
    SRST |=> (FAST_LIMIT_CH1 == LIMIT_RESET))
    else $error("limit reset value wrong");
  a_port_idle: assert property (@(posedge REF_CLK)
    SRST |=> (!RVALID && RDATA == 16'h0000 && !FAST_OVER_CH1))
    else $error("read port or flag not idle after reset");
  a_lim_write: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.wr && REQ.addr == OFS_FAST_LIM1)
      |=> FAST_LIMIT_CH1 == ($past(REQ.wdata) & FIELD_MASK))
    else $error("limit write not taken");
  // The limit feeds the fast compare, so any stray change would shift the trip point
  a_lim_hold: assert property (@(posedge REF_CLK) disable iff (SRST)
    !(REQ.wr && REQ.addr == OFS_FAST_LIM1) |=> $stable(FAST_LIMIT_CH1))
    else $error("limit changed without a write");
  a_ro_ignore: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.wr && REQ.addr inside {[OFS_SHUNT_CH1:OFS_BUS_CH3]} && avg_out_v == '0)
      |=> $stable(st_r.res))
    else $error("write disturbed a result");
  a_res_hold: assert property (@(posedge REF_CLK) disable iff (SRST)
    (avg_out_v == '0) |=> $stable(st_r.res))
    else $error("result moved without a finished average");
  a_shunt_low: assert property (@(posedge REF_CLK) disable iff (SRST)
    (st_r.res[0][2:0] | st_r.res[2][2:0] | st_r.res[4][2:0]) == 3'h0)
    else $error("reserved shunt bits set");
  a_bus_low: assert property (@(posedge REF_CLK) disable iff (SRST)
    (st_r.res[1][2:0] | st_r.res[3][2:0] | st_r.res[5][2:0]) == 3'h0)
    else $error("reserved bus bits set");
  a_rvalid_src: assert property (@(posedge REF_CLK) disable iff (SRST)
    RVALID |-> $past(REQ.rd))
    else $error("read answer without a request");
  a_rd_ch1: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_SHUNT_CH1) |=> RVALID && RDATA == $past(st_r.res[0]))
    else $error("shunt ch1 read wrong");
  a_rd_bus1: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_BUS_CH1) |=> RVALID && RDATA == $past(st_r.res[1]))
    else $error("bus ch1 read wrong");
  a_rd_shunt2: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_SHUNT_CH2) |=> RVALID && RDATA == $past(st_r.res[2]))
    else $error("shunt ch2 read wrong");
  a_rd_bus2: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_BUS_CH2) |=> RVALID && RDATA == $past(st_r.res[3]))
    else $error("bus ch2 read wrong");
  a_rd_shunt3: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_SHUNT_CH3) |=> RVALID && RDATA == $past(st_r.res[4]))
    else $error("shunt ch3 read wrong");
  a_rd_bus3: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_BUS_CH3) |=> RVALID && RDATA == $past(st_r.res[5]))
    else $error("bus ch3 read wrong");
  a_rd_limit: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && REQ.addr == OFS_FAST_LIM1) |=> RVALID && RDATA == $past(st_r.lim))
    else $error("limit read wrong");
  a_rd_unmapped: assert property (@(posedge REF_CLK) disable iff (SRST)
    (REQ.rd && !(REQ.addr inside {[OFS_SHUNT_CH1:OFS_FAST_LIM1]}))
      |=> RVALID && RDATA == 16'h0000)
    else $error("unmapped read not zero");
  // Only raw channel-one shunt conversions may trip the fast flag
  a_over_src: assert property (@(posedge REF_CLK) disable iff (SRST)
    FAST_OVER_CH1 |-> $past(avg_in_v[0]))
    else $error("fast flag from a foreign stream");
  a_sign_kept: assert property (@(posedge REF_CLK) disable iff (SRST)
    (AVG_SEL == 3'h0 && avg_in_v[1])
      |-> ##2 st_r.res[1][15] == $past(SAMPLE.code[15], 2))
    else $error("sign bit lost");

  c_write_lim: cover property (@(posedge REF_CLK) REQ.wr && REQ.addr == OFS_FAST_LIM1);
  c_fast_over: cover property (@(posedge REF_CLK) FAST_OVER_CH1);
  c_avg_done:  cover property (@(posedge REF_CLK) AVG_SEL == 3'h1 && avg_out_v[3]);
  c_ro_write:  cover property (@(posedge REF_CLK) REQ.wr && REQ.addr == OFS_BUS_CH3);
  c_chan_drop: cover property (@(posedge REF_CLK) SAMPLE.valid && SAMPLE.chan == 2'h3);
endmodule

// ===== verif/mrr_host_model.sv
// Host model: issues whole 16-bit register words on the request port.
// Assumes requests launch at the falling edge of the shared clock.
module mrr_host_model
(
  input  wire logic          clk,
  input  wire logic [15:0]   rdata,
  input  wire logic          rvalid,
  output mrr_pkg::mrr_req_t  req
);
  timeunit 1ns;
  timeprecision 1ps;
  import mrr_pkg::*;

  initial req = '0;

  // ==========================================================
  // Word transfers; byte split belongs to the serial engine
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // Answer is a one-cycle pulse, so it is taken at the very next falling edge
  task automatic rd_word(input logic [7:0] a, output logic [15:0] d, output bit ok);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    ok = (rvalid === 1'b1);
    d = rdata;
  endtask
endmodule

// ===== verif/mrr_result_bank_tb_top.sv
// Testbench of the result and fast-limit register bank, with a register model.
// Assumes the host model drives the request port and this bench the samples.
module mrr_result_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mrr_pkg::*;

  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  mrr_req_t    req;
  mrr_sample_t sample = '0;
  logic [2:0]  avg_sel = 3'h0;
  logic [15:0] rdata;
  logic [15:0] fast_limit;
  logic        rvalid;
  logic        fast_over;
  logic [15:0] model_reg [0:8];
  logic [15:0] v;
  longint      sum;
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 32'h90af_dc4c;
  int          sh_tab [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  logic [15:0] codes [6] = '{16'h0100, 16'h0108, 16'h0107, 16'hc180, 16'h7ff8, 16'h8000};

  always #2 ref_clk = ~ref_clk;

  mrr_host_model host (.clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

  mrr_result_bank dut (.REF_CLK(ref_clk), .SRST(srst), .REQ(req), .RDATA(rdata),
    .RVALID(rvalid), .SAMPLE(sample), .AVG_SEL(avg_sel), .FAST_OVER_CH1(fast_over),
    .FAST_LIMIT_CH1(fast_limit));

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [15:0] d;
    bit          ok;
    host.rd_word(a, d, ok);
    if (!ok)
    begin
      fail_count++;
      $display("wrong value at %0t: no read answer", $time);
      test_done();
    end
    check(d, model_reg[a], "read");
  endtask

  task automatic do_reset(input logic [2:0] sel);
    @(negedge ref_clk);
    srst = 1'b1;
    avg_sel = sel;
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    foreach (model_reg[i]) model_reg[i] = 16'h0000;
    model_reg[7] = 16'h7ff8;
  endtask

  // Extra falling edge lets the two-stage result update land before a read
  task automatic send(input logic [1:0] ch, input logic bus, input logic [15:0] c);
    logic exp_over;
    exp_over = ch == 2'h0 && !bus && $signed(c & 16'hfff8) > $signed(model_reg[7]);
    @(negedge ref_clk);
    sample = '{valid: 1'b1, chan: ch, is_bus: bus, code: c};
    @(negedge ref_clk);
    sample = '0;
    check({15'h0, fast_over}, {15'h0, exp_over}, "fast");
    @(negedge ref_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    do_reset(3'h0);
    for (int a = 0; a <= 8; a++) rd_chk(a[7:0]);
    for (int a = 1; a <= 8; a++)
      if (a != 7) host.wr_word(a[7:0], 16'hffff);
    v = 16'($random(seed));
    host.wr_word(8'h07, v);
    model_reg[7] = v & 16'hfff8;
    check(fast_limit, model_reg[7], "limit port");
    for (int a = 0; a <= 8; a++) rd_chk(a[7:0]);
    host.wr_word(8'h07, 16'h0100);
    model_reg[7] = 16'h0100;
    for (int i = 0; i < 30; i++)
    begin
      v = (i < 6) ? codes[i] : 16'($random(seed));
      send((i < 6) ? 2'd0 : 2'(i % 3), (i < 6) ? 1'b0 : 1'((i / 3) % 2), v);
      model_reg[(i < 6) ? 1 : (i % 3) * 2 + 1 + (i / 3) % 2] = v & 16'hfff8;
      for (int a = 1; a <= 6; a++) rd_chk(a[7:0]);
    end
    send(2'd3, 1'b0, 16'h1238);
    for (int a = 1; a <= 6; a++) rd_chk(a[7:0]);
    // Each averaging code, from a clean running sum after reset
    for (int s = 0; s < 8; s++)
    begin
      do_reset(3'(s));
      rd_chk(8'h01);
      rd_chk(8'h07);
      sum = 0;
      for (int n = 0; n < (1 << sh_tab[s]); n++)
      begin
        @(negedge ref_clk);
        v = 16'($random(seed)) & 16'hfff8;
        sample = '{valid: 1'b1, chan: 2'd1, is_bus: 1'b1, code: v};
        sum += $signed(v);
      end
      @(negedge ref_clk);
      sample = '0;
      repeat (2) @(negedge ref_clk);
      model_reg[4] = 16'(sum >>> sh_tab[s]) & 16'hfff8;
      rd_chk(8'h04);
    end
    test_done();
  end

  // Run-length guard
  initial
  begin
    #400000;
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    test_done();
  end
endmodule
